// ===== logic/oag_pkg.sv
package oag_pkg;

	// Operand size codes
	typedef enum logic [1:0] {
		OAG_SZ_BYTE = 2'h0,
		OAG_SZ_WORD = 2'h1,
		OAG_SZ_LONG = 2'h2
	} oag_size_t;

	// Effective-address mode field values
	localparam logic [2:0] OAG_M_DREG    = 3'h0;
	localparam logic [2:0] OAG_M_AREG    = 3'h1;
	localparam logic [2:0] OAG_M_IND     = 3'h2;
	localparam logic [2:0] OAG_M_POSTINC = 3'h3;
	localparam logic [2:0] OAG_M_PREDEC  = 3'h4;
	localparam logic [2:0] OAG_M_DISP    = 3'h5;
	localparam logic [2:0] OAG_M_INDEX   = 3'h6;
	localparam logic [2:0] OAG_M_SPECIAL = 3'h7;

	// Operation word field positions
	localparam int OAG_EA_MODE_LSB = 3;
	localparam int OAG_EA_REG_LSB  = 0;

	// Index extension word field positions
	localparam int OAG_IX_DA_BIT  = 15;
	localparam int OAG_IX_REG_LSB = 12;
	localparam int OAG_IX_WL_BIT  = 11;

	localparam logic [2:0] OAG_SP_NUM    = 3'h7;
	localparam logic [2:0] OAG_MAX_WORDS = 3'h5;

	// Function codes driven with each reference
	localparam logic [2:0] OAG_FC_USER_DATA = 3'h1;
	localparam logic [2:0] OAG_FC_USER_PROG = 3'h2;
	localparam logic [2:0] OAG_FC_SUP_DATA  = 3'h5;
	localparam logic [2:0] OAG_FC_SUP_PROG  = 3'h6;

	localparam logic [31:0] OAG_RST_WORD = 32'h0000_0000;

	typedef enum logic [3:0] {
		OAG_ST_IDLE = 4'h1,
		OAG_ST_EXT  = 4'h2,
		OAG_ST_CALC = 4'h4,
		OAG_ST_END  = 4'h8
	} oag_state_t;

	function automatic logic [31:0] oag_sext16(input logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction

	function automatic logic [31:0] oag_sext8(input logic [7:0] v);
		return {{24{v[7]}}, v};
	endfunction

	// Auto-modify step; byte on the stack pointer keeps word alignment
	function automatic logic [31:0] oag_step(input oag_size_t sz, input logic is_sp);
		case (sz)
			OAG_SZ_BYTE: return is_sp ? 32'h0000_0002 : 32'h0000_0001;
			OAG_SZ_WORD: return 32'h0000_0002;
			default:     return 32'h0000_0004;
		endcase
	endfunction

	// Low-order slice of a data register, upper bits unused
	function automatic logic [31:0] oag_dslice(input logic [31:0] v, input oag_size_t sz);
		case (sz)
			OAG_SZ_BYTE: return {24'h000000, v[7:0]};
			OAG_SZ_WORD: return {16'h0000, v[15:0]};
			default:     return v;
		endcase
	endfunction

endpackage

// ===== logic/oag_rf_if.sv
`timescale 1ns/100ps
`default_nettype none
interface oag_rf_if;
	import oag_pkg::*;
	logic        sup;
	logic [2:0]  d_rsel;
	logic [2:0]  a_rsel;
	logic        x_is_a;
	logic [2:0]  x_rsel;
	logic [31:0] d_q;
	logic [31:0] a_q;
	logic [31:0] x_q;
	logic        d_we;
	logic [2:0]  d_wsel;
	oag_size_t   d_wsz;
	logic [31:0] d_wdata;
	logic        a_we;
	logic [2:0]  a_wsel;
	logic [31:0] a_wdata;

	modport ctl (
		output sup, d_rsel, a_rsel, x_is_a, x_rsel,
		output d_we, d_wsel, d_wsz, d_wdata, a_we, a_wsel, a_wdata,
		input  d_q, a_q, x_q
	);
	modport rf (
		input  sup, d_rsel, a_rsel, x_is_a, x_rsel,
		input  d_we, d_wsel, d_wsz, d_wdata, a_we, a_wsel, a_wdata,
		output d_q, a_q, x_q
	);
endinterface
`default_nettype wire

// ===== logic/oag_regfile.sv
`timescale 1ns/100ps
`default_nettype none
module oag_regfile
	import oag_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic nrst,
	oag_rf_if.rf      rf
);

	typedef struct packed {
		logic [7:0][31:0] dr;
		logic [6:0][31:0] ar;
		logic [31:0]      user_stack_pointer;
		logic [31:0]      supervisor_stack_pointer;
	} oag_rf_t;

	oag_rf_t st_reg;
	oag_rf_t st_next;

	// Register seven resolves to the stack of the current state
	function automatic logic [31:0] oag_aread(input oag_rf_t s, input logic [2:0] n, input logic sup);
		if (n == OAG_SP_NUM)
			return sup ? s.supervisor_stack_pointer : s.user_stack_pointer;
		return s.ar[n];
	endfunction

	always_comb begin
		rf.d_q = st_reg.dr[rf.d_rsel];
		rf.a_q = oag_aread(st_reg, rf.a_rsel, rf.sup);
		rf.x_q = rf.x_is_a ? oag_aread(st_reg, rf.x_rsel, rf.sup) : st_reg.dr[rf.x_rsel];
	end

	always_comb begin
		st_next = st_reg;
		if (rf.d_we) begin
			// Only the slice of the operand size changes
			case (rf.d_wsz)
				OAG_SZ_BYTE: st_next.dr[rf.d_wsel][7:0]  = rf.d_wdata[7:0];
				OAG_SZ_WORD: st_next.dr[rf.d_wsel][15:0] = rf.d_wdata[15:0];
				default:     st_next.dr[rf.d_wsel]       = rf.d_wdata;
			endcase
		end
		if (rf.a_we) begin
			// Address registers are always written whole
			if (rf.a_wsel != OAG_SP_NUM)
				st_next.ar[rf.a_wsel] = rf.a_wdata;
			else if (rf.sup)
				st_next.supervisor_stack_pointer = rf.a_wdata;
			else
				st_next.user_stack_pointer = rf.a_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

endmodule // oag_regfile
`default_nettype wire

// ===== logic/oag_ea_calc.sv
`timescale 1ns/100ps
`default_nettype none
module oag_ea_calc
	import oag_pkg::*;
(
	input  wire logic [2:0]  mode,
	input  wire logic [2:0]  reg_num,
	input  wire oag_size_t   size,
	input  wire logic [31:0] base,
	input  wire logic [15:0] ext,
	input  wire logic        ix_long,
	input  wire logic [31:0] index,
	output var  logic [31:0] addr,
	output var  logic [31:0] areg_new,
	output var  logic        areg_upd
);

	logic [31:0] step;
	logic [31:0] ix_val;

	always_comb begin
		step     = oag_step(size, reg_num == OAG_SP_NUM);
		ix_val   = ix_long ? index : oag_sext16(index[15:0]);
		addr     = base;
		areg_new = base;
		areg_upd = 1'b0;
		case (mode)
			OAG_M_POSTINC: begin
				areg_new = base + step;
				areg_upd = 1'b1;
			end
			OAG_M_PREDEC: begin
				addr     = base - step;
				areg_new = base - step;
				areg_upd = 1'b1;
			end
			OAG_M_DISP:  addr = base + oag_sext16(ext);
			OAG_M_INDEX: addr = base + oag_sext8(ext[7:0]) + ix_val;
			default:     addr = base;
		endcase
	end

endmodule // oag_ea_calc
`default_nettype wire

// ===== logic/oag_top.sv
// Function
// - Operand size is byte 8, word 16 or long 32 bits.
// - Instruction words are fetched from even, word-aligned addresses.
// - Eight 32-bit data registers, seven address registers and stack pointers.
// - Byte uses bits 7:0, word 15:0, long 31:0.
// - Data register access touches only the size slice; upper bits keep.
// - Address registers refuse bytes; word reads low 16, long all. A byte writeback to An is not refused; it writes all 32 bits.
// - Address register writes are full 32 bits; word data sign-extended.
// - Instructions are one to five words and start word aligned.
// - Length comes from the operation word; extension words follow.
// - Operand reads data space except PC-relative; writes data; function codes.
// - Effective address is a 3-bit mode and 3-bit register field.
// - Extension words are the ones right after the operation word.
// - Data-register-direct operand is the selected data register.
// - Address-register-direct operand is the selected address register.
// - Indirect address is the register; jumps make it a program reference.
// - Post-increment adds 1, 2 or 4 after use.
// - Byte post-increment of the stack pointer adds 2.
// - Pre-decrement subtracts 1, 2 or 4 before use.
// - Byte pre-decrement of stack pointer subtracts 2; auto modes are data.
// - Displacement adds the sign-extended 16-bit extension word.
// - Index adds sign-extended low byte plus the index register.
// - Modes 0 to 6 are register modes; 7 selects special modes.
// - Register seven is supervisor or user stack pointer by state.
`timescale 1ns/100ps
`default_nettype none
module oag_top
	import oag_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        req_valid,
	input  wire logic [15:0] op_word,
	input  wire logic [1:0]  op_size,
	input  wire logic        op_jump,
	input  wire logic        op_write,
	input  wire logic        op_sup,
	input  wire logic [31:0] op_pc,
	input  wire logic        ext_valid,
	input  wire logic [15:0] ext_word,
	input  wire logic        wb_valid,
	input  wire logic        wb_is_addr,
	input  wire logic [2:0]  wb_reg,
	input  wire logic [1:0]  wb_size,
	input  wire logic        wb_sup,
	input  wire logic [31:0] wb_data,
	output var  logic        busy,
	output var  logic        ext_req,
	output var  logic [31:0] fetch_addr,
	output var  logic        done,
	output var  logic        err,
	output var  logic        is_mem,
	output var  logic [31:0] ea_addr,
	output var  logic [31:0] operand,
	output var  logic        prog_ref,
	output var  logic [2:0]  fc,
	output var  logic [2:0]  len_words
);

	typedef struct packed {
		oag_state_t  st;
		logic [2:0]  mode;
		logic [2:0]  rn;
		oag_size_t   sz;
		logic        jmp;
		logic        wr;
		logic        sup;
		logic [15:0] ext;
		logic        busy;
		logic        ext_req;
		logic [31:0] fetch_addr;
		logic        done;
		logic        err;
		logic        is_mem;
		logic [31:0] addr;
		logic [31:0] operand;
		logic        prog_ref;
		logic [2:0]  fc;
		logic [2:0]  len;
	} oag_top_t;

	oag_top_t s_reg;
	oag_top_t s_next;

	oag_rf_if rfi ();

	logic [31:0] calc_addr;
	logic [31:0] calc_anew;
	logic        calc_upd;
	logic        needs_ext;
	logic        bad_ea;
	oag_size_t   req_sz;
	logic [2:0]  req_mode;
	logic [2:0]  req_rn;
	logic        wb_take;

	oag_regfile u_regfile (
		.core_clk (core_clk),
		.nrst     (nrst),
		.rf       (rfi.rf)
	);

	oag_ea_calc u_ea_calc (
		.mode     (s_reg.mode),
		.reg_num  (s_reg.rn),
		.size     (s_reg.sz),
		.base     (rfi.a_q),
		.ext      (s_reg.ext),
		.ix_long  (s_reg.ext[OAG_IX_WL_BIT]),
		.index    (rfi.x_q),
		.addr     (calc_addr),
		.areg_new (calc_anew),
		.areg_upd (calc_upd)
	);

	// Function code from state and reference class
	function automatic logic [2:0] oag_fc(input logic sup, input logic prog);
		if (sup)
			return prog ? OAG_FC_SUP_PROG : OAG_FC_SUP_DATA;
		return prog ? OAG_FC_USER_PROG : OAG_FC_USER_DATA;
	endfunction

	always_comb begin
		req_mode  = op_word[OAG_EA_MODE_LSB +: 3];
		req_rn    = op_word[OAG_EA_REG_LSB +: 3];
		req_sz    = oag_size_t'(op_size);
		needs_ext = (req_mode == OAG_M_DISP) || (req_mode == OAG_M_INDEX);
		// Special modes live outside this block; byte to An is illegal
		bad_ea    = (req_mode == OAG_M_SPECIAL) ||
			((req_mode == OAG_M_AREG) && (req_sz == OAG_SZ_BYTE)) ||
			(op_size == 2'h3) || op_pc[0];
		wb_take   = wb_valid && (s_reg.st == OAG_ST_IDLE);
	end

	// Register file port steering
	always_comb begin
		rfi.sup     = wb_take ? wb_sup : s_reg.sup;
		rfi.d_rsel  = s_reg.rn;
		rfi.a_rsel  = s_reg.rn;
		rfi.x_is_a  = s_reg.ext[OAG_IX_DA_BIT];
		rfi.x_rsel  = s_reg.ext[OAG_IX_REG_LSB +: 3];
		rfi.d_we    = wb_take && !wb_is_addr;
		rfi.d_wsel  = wb_reg;
		rfi.d_wsz   = oag_size_t'(wb_size);
		rfi.d_wdata = wb_data;
		rfi.a_we    = 1'b0;
		rfi.a_wsel  = wb_reg;
		rfi.a_wdata = wb_data;
		if (wb_take && wb_is_addr) begin
			rfi.a_we    = 1'b1;
			// Word data widened before it reaches the register
			rfi.a_wdata = (oag_size_t'(wb_size) == OAG_SZ_WORD) ?
				oag_sext16(wb_data[15:0]) : wb_data;
		end else if (s_reg.st == OAG_ST_CALC && calc_upd) begin
			rfi.a_we    = 1'b1;
			rfi.a_wsel  = s_reg.rn;
			rfi.a_wdata = calc_anew;
		end
	end

	always_comb begin
		s_next      = s_reg;
		s_next.done = 1'b0;
		case (s_reg.st)
			OAG_ST_IDLE: begin
				// Writeback has the port this cycle, so the request waits
				if (req_valid && !wb_valid) begin
					s_next.mode     = req_mode;
					s_next.rn       = req_rn;
					s_next.sz       = req_sz;
					s_next.jmp      = op_jump;
					s_next.wr       = op_write;
					s_next.sup      = op_sup;
					s_next.ext      = 16'h0000;
					s_next.busy     = 1'b1;
					s_next.err      = 1'b0;
					s_next.len      = needs_ext ? 3'h2 : 3'h1;
					if (bad_ea) begin
						s_next.err = 1'b1;
						s_next.st  = OAG_ST_END;
					end else if (needs_ext) begin
						s_next.ext_req    = 1'b1;
						// Word right after the operation word, even address
						s_next.fetch_addr = {op_pc[31:1], 1'b0} + 32'h0000_0002;
						s_next.st         = OAG_ST_EXT;
					end else begin
						s_next.st = OAG_ST_CALC;
					end
				end
			end
			OAG_ST_EXT: begin
				if (ext_valid) begin
					s_next.ext     = ext_word;
					s_next.ext_req = 1'b0;
					s_next.st      = OAG_ST_CALC;
				end
			end
			OAG_ST_CALC: begin
				s_next.is_mem   = (s_reg.mode != OAG_M_DREG) && (s_reg.mode != OAG_M_AREG);
				s_next.addr     = s_next.is_mem ? calc_addr : OAG_RST_WORD;
				s_next.operand  = OAG_RST_WORD;
				if (s_reg.mode == OAG_M_DREG)
					s_next.operand = oag_dslice(rfi.d_q, s_reg.sz);
				else if (s_reg.mode == OAG_M_AREG)
					s_next.operand = (s_reg.sz == OAG_SZ_WORD) ?
						{16'h0000, rfi.a_q[15:0]} : rfi.a_q;
				// Jumps fetch program; auto modes and writes stay data
				s_next.prog_ref = s_reg.jmp && !s_reg.wr &&
					((s_reg.mode == OAG_M_IND) || (s_reg.mode == OAG_M_DISP) ||
					(s_reg.mode == OAG_M_INDEX));
				s_next.fc       = oag_fc(s_reg.sup, s_next.prog_ref);
				s_next.st       = OAG_ST_END;
			end
			OAG_ST_END: begin
				s_next.done = 1'b1;
				s_next.busy = 1'b0;
				s_next.st   = OAG_ST_IDLE;
			end
			default: begin
				s_next.st = OAG_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			s_reg    <= '0;
			s_reg.st <= OAG_ST_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign busy       = s_reg.busy;
	assign ext_req    = s_reg.ext_req;
	assign fetch_addr = s_reg.fetch_addr;
	assign done       = s_reg.done;
	assign err        = s_reg.err;
	assign is_mem     = s_reg.is_mem;
	assign ea_addr    = s_reg.addr;
	assign operand    = s_reg.operand;
	assign prog_ref   = s_reg.prog_ref;
	assign fc         = s_reg.fc;
	assign len_words  = s_reg.len;

endmodule // oag_top
`default_nettype wire

// ===== verif/oag_top_props.sv
`timescale 1ns/100ps
`default_nettype none
module oag_top_props (
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic        req_valid,
	input wire logic        ext_valid,
	input wire logic        wb_valid,
	input wire logic        busy,
	input wire logic        ext_req,
	input wire logic [31:0] fetch_addr,
	input wire logic        done,
	input wire logic        is_mem,
	input wire logic [31:0] ea_addr,
	input wire logic        prog_ref,
	input wire logic [2:0]  fc,
	input wire logic [2:0]  len_words
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	AST_DONE_PULSE: assert property (done |=> !done) else $error("done longer than one cycle");
	AST_DONE_IDLE: assert property (done |-> !busy && !ext_req) else $error("done while busy");
	AST_TAKE: assert property (!busy && !done && req_valid && !wb_valid |=> busy)
		else $error("idle request not taken");
	AST_ANSWER: assert property ($rose(busy) |-> ##[1:40] done) else $error("no answer to request");
	AST_EXT_EVEN: assert property (ext_req |-> fetch_addr[0] == 1'b0) else $error("odd fetch address");
	AST_EXT_HOLD: assert property (ext_req && !ext_valid |=> ext_req && $stable(fetch_addr))
		else $error("extension request dropped early");
	AST_EXT_DROP: assert property (ext_req && ext_valid |=> !ext_req) else $error("extension taken twice");
	AST_LEN: assert property (done |-> len_words inside {3'h1, 3'h2}) else $error("bad length");
	AST_FC: assert property (done && is_mem |-> fc[1:0] == (prog_ref ? 2'h2 : 2'h1))
		else $error("function code mismatch");
	AST_DIRECT: assert property (done && !is_mem |-> ea_addr == 32'h0 && !prog_ref)
		else $error("direct mode gave address");
endmodule // oag_top_props
bind oag_top oag_top_props u_props (
	.core_clk(core_clk), .nrst(nrst), .req_valid(req_valid), .ext_valid(ext_valid),
	.wb_valid(wb_valid), .busy(busy), .ext_req(ext_req), .fetch_addr(fetch_addr), .done(done),
	.is_mem(is_mem), .ea_addr(ea_addr), .prog_ref(prog_ref), .fc(fc), .len_words(len_words)
);
`default_nettype wire

// ===== verif/oag_ext_src.sv
`timescale 1ns/100ps
`default_nettype none
module oag_ext_src (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        ext_req,
	input  wire logic [15:0] src_word,
	input  wire logic [3:0]  src_lat,
	output var  logic        ext_valid,
	output var  logic [15:0] ext_word
);
	logic [3:0] cnt_reg;

	// Released bus shows the inverse, never the stale word
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cnt_reg   <= 4'h0;
			ext_valid <= 1'b0;
			ext_word  <= 16'h0000;
		end else if (ext_valid) begin
			cnt_reg   <= 4'h0;
			ext_valid <= 1'b0;
			ext_word  <= ~ext_word;
		end else if (ext_req) begin
			if (cnt_reg == src_lat) begin
				ext_valid <= 1'b1;
				ext_word  <= src_word;
			end else begin
				cnt_reg <= cnt_reg + 4'h1;
			end
		end
	end
endmodule // oag_ext_src
`default_nettype wire

// ===== verif/tb_operand_address_generator.sv
`timescale 1ns/100ps
`default_nettype none
module tb_operand_address_generator;
	logic        core_clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, op_jump = 1'b0, op_write = 1'b0;
	logic        op_sup = 1'b0, wb_valid = 1'b0, wb_is_addr = 1'b0, wb_sup = 1'b0;
	logic [15:0] op_word = 16'h0, src_word = 16'h0, ext_word;
	logic [1:0]  op_size = 2'h0, wb_size = 2'h0;
	logic [2:0]  wb_reg = 3'h0, fc, len_words;
	logic [31:0] op_pc = 32'h0000_0100, wb_data = 32'h0, fetch_addr, ea_addr, operand, fa;
	logic [3:0]  src_lat = 4'h2;
	logic        ext_valid, busy, ext_req, done, err, is_mem, prog_ref;
	int          miscompares = 0, tests_run = 0;

	always #4 core_clk = ~core_clk;

	oag_top u_dut (.core_clk(core_clk), .nrst(nrst), .req_valid(req_valid), .op_word(op_word),
		.op_size(op_size), .op_jump(op_jump), .op_write(op_write), .op_sup(op_sup), .op_pc(op_pc),
		.ext_valid(ext_valid), .ext_word(ext_word), .wb_valid(wb_valid), .wb_is_addr(wb_is_addr),
		.wb_reg(wb_reg), .wb_size(wb_size), .wb_sup(wb_sup), .wb_data(wb_data), .busy(busy),
		.ext_req(ext_req), .fetch_addr(fetch_addr), .done(done), .err(err), .is_mem(is_mem),
		.ea_addr(ea_addr), .operand(operand), .prog_ref(prog_ref), .fc(fc), .len_words(len_words));
	oag_ext_src u_src (.core_clk(core_clk), .nrst(nrst), .ext_req(ext_req), .src_word(src_word),
		.src_lat(src_lat), .ext_valid(ext_valid), .ext_word(ext_word));

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wb(input logic a, input logic [2:0] r, input logic [1:0] sz, input logic s, input logic [31:0] d);
		@(posedge core_clk);
		#1;
		{wb_valid, wb_is_addr, wb_reg, wb_size, wb_sup, wb_data} = {1'b1, a, r, sz, s, d};
		@(posedge core_clk);
		#1;
		wb_valid = 1'b0;
	endtask

	task automatic rq(input logic [2:0] m, input logic [2:0] r, input logic [1:0] sz, input logic j,
		input logic s, input logic [15:0] x);
		int n;
		@(posedge core_clk);
		#1;
		{req_valid, op_word, op_size, op_jump, op_sup, src_word} = {1'b1, 10'h000, m, r, sz, j, s, x};
		@(posedge core_clk);
		#1;
		req_valid = 1'b0;
		for (n = 0; n < 50 && done !== 1'b1; n++) begin
			if (ext_req === 1'b1)
				fa = fetch_addr;
			@(posedge core_clk);
			#1;
		end
		if (done !== 1'b1) begin
			miscompares++;
			end_of_test();
		end
	endtask

	task automatic s_dreg();
		wb(1'b0, 3'h3, 2'h2, 1'b0, 32'h1234_5678);
		wb(1'b0, 3'h3, 2'h0, 1'b0, 32'hFFFF_FFAB);
		rq(3'h0, 3'h3, 2'h0, 1'b0, 1'b1, 16'h0);
		chk(operand, 32'h0000_00AB);
		chk(32'(is_mem), 32'h0);
		rq(3'h0, 3'h3, 2'h1, 1'b0, 1'b1, 16'h0);
		chk(operand, 32'h0000_56AB);
		rq(3'h0, 3'h3, 2'h2, 1'b0, 1'b1, 16'h0);
		chk(operand, 32'h1234_56AB);
	endtask

	task automatic s_areg();
		wb(1'b1, 3'h2, 2'h1, 1'b0, 32'h0000_8000);
		rq(3'h1, 3'h2, 2'h2, 1'b0, 1'b1, 16'h0);
		chk(operand, 32'hFFFF_8000);
		rq(3'h1, 3'h2, 2'h1, 1'b0, 1'b1, 16'h0);
		chk(operand, 32'h0000_8000);
		rq(3'h1, 3'h2, 2'h0, 1'b0, 1'b1, 16'h0);
		chk(32'(err), 32'h1);
		rq(3'h7, 3'h0, 2'h1, 1'b0, 1'b1, 16'h0);
		chk(32'(err), 32'h1);
		rq(3'h0, 3'h3, 2'h3, 1'b0, 1'b1, 16'h0);
		chk(32'(err), 32'h1);
		op_pc = 32'h0000_0101;
		rq(3'h2, 3'h2, 2'h1, 1'b0, 1'b1, 16'h0);
		op_pc = 32'h0000_0100;
		chk(32'(err), 32'h1);
		rq(3'h1, 3'h2, 2'h2, 1'b0, 1'b1, 16'h0);
		chk(32'(err), 32'h0);
	endtask

	task automatic s_reset();
		@(posedge core_clk);
		#1;
		nrst = 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		nrst = 1'b1;
		chk(32'({busy, ext_req, done, err, is_mem, prog_ref}), 32'h0);
		chk(ea_addr, 32'h0);
		rq(3'h0, 3'h3, 2'h2, 1'b0, 1'b1, 16'h0);
		chk(operand, 32'h0);
		rq(3'h1, 3'h7, 2'h2, 1'b0, 1'b1, 16'h0);
		chk(operand, 32'h0);
	endtask

	task automatic s_auto();
		logic [31:0] st;
		for (int z = 0; z < 3; z++) begin
			st = 32'h1 << z;
			wb(1'b1, 3'h1, 2'h2, 1'b0, 32'h0000_1000);
			rq(3'h3, 3'h1, 2'(z), 1'b0, 1'b1, 16'h0);
			chk(ea_addr, 32'h0000_1000);
			chk(32'(fc), 32'h5);
			rq(3'h2, 3'h1, 2'(z), 1'b0, 1'b1, 16'h0);
			chk(ea_addr, 32'h0000_1000 + st);
			rq(3'h4, 3'h1, 2'(z), 1'b0, 1'b1, 16'h0);
			chk(ea_addr, 32'h0000_1000);
		end
		wb(1'b1, 3'h7, 2'h2, 1'b1, 32'h0000_4000);
		wb(1'b1, 3'h7, 2'h2, 1'b0, 32'h0000_5000);
		rq(3'h3, 3'h7, 2'h0, 1'b0, 1'b1, 16'h0);
		chk(ea_addr, 32'h0000_4000);
		rq(3'h4, 3'h7, 2'h0, 1'b0, 1'b0, 16'h0);
		chk(ea_addr, 32'h0000_4FFE);
		chk(32'(fc), 32'h1);
		rq(3'h2, 3'h7, 2'h0, 1'b1, 1'b1, 16'h0);
		chk(ea_addr, 32'h0000_4002);
		chk(32'(fc), 32'h6);
	endtask

	task automatic s_ext();
		wb(1'b1, 3'h4, 2'h2, 1'b0, 32'h0000_2000);
		rq(3'h5, 3'h4, 2'h1, 1'b1, 1'b0, 16'hFFFE);
		chk(ea_addr, 32'h0000_1FFE);
		chk(32'(fc), 32'h2);
		chk(32'(len_words), 32'h2);
		chk(fa, op_pc + 32'h2);
		op_write = 1'b1;
		rq(3'h5, 3'h4, 2'h1, 1'b1, 1'b0, 16'h0010);
		op_write = 1'b0;
		chk(32'(prog_ref), 32'h0);
		src_lat = 4'h0;
		wb(1'b0, 3'h6, 2'h2, 1'b0, 32'h0000_0010);
		wb(1'b1, 3'h5, 2'h2, 1'b0, 32'h0000_3000);
		rq(3'h6, 3'h5, 2'h2, 1'b0, 1'b1, 16'h6880);
		chk(ea_addr, 32'h0000_2F90);
		wb(1'b0, 3'h6, 2'h1, 1'b0, 32'h0000_FFF0);
		rq(3'h6, 3'h5, 2'h2, 1'b0, 1'b1, 16'h6004);
		chk(ea_addr, 32'h0000_2FF4);
	endtask

	initial begin
		repeat (16) @(posedge core_clk);
		#1;
		nrst = 1'b1;
		s_dreg();
		s_areg();
		s_auto();
		s_ext();
		s_reset();
		end_of_test();
	end
endmodule // tb_operand_address_generator
`default_nettype wire
